//--- logic/rrs_regs.svh
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH
// clock period in ns
`define RRS_CLK_NS 10
// power-on delay in us, then cycles
`define RRS_PWR_US 1000
`define RRS_PWR_CYC ((`RRS_PWR_US * 1000) / `RRS_CLK_NS)
// reset pulse window in ns (least 10, most 1000)
`define RRS_RST_MIN_NS 10
`define RRS_RST_MIN_CYC ((`RRS_RST_MIN_NS + `RRS_CLK_NS - 1) / `RRS_CLK_NS)
`define RRS_RST_MAX_NS 1000
`define RRS_RST_MAX_CYC (`RRS_RST_MAX_NS / `RRS_CLK_NS)
// release to serial enable in ns
`define RRS_SEN_NS 100
`define RRS_SEN_CYC ((`RRS_SEN_NS + `RRS_CLK_NS - 1) / `RRS_CLK_NS)
// pipeline latencies in sample cycles
`define RRS_LAT_LOW 10
`define RRS_LAT_GAIN 16
`define RRS_LAT_GAIN_OFS 17
// register offsets and values
`define RRS_ADDR_READOUT 8'h00
`define RRS_BIT_READOUT 0
`define RRS_ADDR_LAT 8'h01
`define RRS_BIT_LOWLAT_DIS 0
`define RRS_BIT_GAIN_EN 1
`define RRS_BIT_OFS_EN 2
`define RRS_BIT_LATE_CLK 3
`define RRS_BIT_CMOS 4
`define RRS_ADDR_PDN 8'h43
`define RRS_VAL_PDN 8'h40
// serial frame: 8 address bits then 8 data bits
`define RRS_FRAME_BITS 16
// serial bit period in cycles
`define RRS_SCLK_DIV 4
`endif

//--- logic/rrs_pkg.sv
package rrs_pkg;
    typedef logic [11:0] rrs_sample_t;
    typedef logic [7:0] rrs_byte_t;
    typedef enum logic [4:0] {
        RRS_H_PWR = 5'b00001,
        RRS_H_RST = 5'b00010,
        RRS_H_GAP = 5'b00100,
        RRS_H_IDLE = 5'b01000,
        RRS_H_SHIFT = 5'b10000
    } rrs_host_st_t;
endpackage

//--- logic/rrs_link_if.sv
`timescale 1ns/1ps
interface rrs_link_if;
    logic reset;
    logic serial_enable;
    logic sclk;
    logic sdata;
    logic overrange_or_readback_pin;
    logic [5:0] lvds_pair;
    logic [11:0] cmos_data;
    logic out_clk;
    modport device (input reset, input serial_enable, input sclk, input sdata,
        output overrange_or_readback_pin, output lvds_pair, output cmos_data, output out_clk);
    modport host (output reset, output serial_enable, output sclk, output sdata,
        input overrange_or_readback_pin, input lvds_pair, input cmos_data, input out_clk);
endinterface

//--- logic/rrs_device.sv
`timescale 1ns/1ps
`include "rrs_regs.svh"
// Functional notes
// - host waits 1 ms after supplies
// - reset pulse 10 ns to 1 us
// - 100 ns from release to enable
// - reset active high clears serial registers
// - long reset briefly enters parallel mode
// - parallel configuration holds reset high
// - late output clock adds one cycle
// - lvds pair carries even and odd bit
// - cmos pin carries one bit per sample
// - shared pin: overrange or readback by select
// - read 43h returns contents; 40h powers down
// - reset default low latency, 10 cycles
// - 16 cycles gain, 17 with offset
// - frame is address byte then data byte
module rrs_device (
    input wire logic mclk,
    input wire logic arst_n,
    rrs_link_if.device link,
    input wire rrs_pkg::rrs_sample_t sample_in,
    input wire logic sample_overrange,
    output logic sample_ready,
    output logic full_power_down,
    output logic parallel_mode
);
    //////////////////////////////////////////////////////////////////////
    // three-stage synchronisers for link pins
    logic [2:0] rst_s_reg, sen_s_reg, sclk_s_reg, sd_s_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s_reg <= 3'h0;
            sen_s_reg <= 3'h0;
            sclk_s_reg <= 3'h0;
            sd_s_reg <= 3'h0;
        end else begin
            rst_s_reg <= {rst_s_reg[1:0], link.reset};
            sen_s_reg <= {sen_s_reg[1:0], link.serial_enable};
            sclk_s_reg <= {sclk_s_reg[1:0], link.sclk};
            sd_s_reg <= {sd_s_reg[1:0], link.sdata};
        end
    end
    // a change counts once stages two and three agree
    logic rst_f_reg, sen_f_reg, sclk_f_reg, sd_f_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_f_reg <= 1'b0;
            sen_f_reg <= 1'b0;
            sclk_f_reg <= 1'b0;
            sd_f_reg <= 1'b0;
        end else begin
            if (rst_s_reg[1] == rst_s_reg[2]) rst_f_reg <= rst_s_reg[2];
            if (sen_s_reg[1] == sen_s_reg[2]) sen_f_reg <= sen_s_reg[2];
            if (sclk_s_reg[1] == sclk_s_reg[2]) sclk_f_reg <= sclk_s_reg[2];
            if (sd_s_reg[1] == sd_s_reg[2]) sd_f_reg <= sd_s_reg[2];
        end
    end
    logic sclk_d_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) sclk_d_reg <= 1'b0;
        else sclk_d_reg <= sclk_f_reg;
    end
    wire sclk_rise = sclk_f_reg & ~sclk_d_reg;
    wire sclk_fall = ~sclk_f_reg & sclk_d_reg;
    //////////////////////////////////////////////////////////////////////
    // reset length: long or held high means parallel configuration
    logic [7:0] rst_cnt_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) rst_cnt_reg <= 8'h00;
        else if (!rst_f_reg) rst_cnt_reg <= 8'h00;
        else if (rst_cnt_reg != 8'hFF) rst_cnt_reg <= rst_cnt_reg + 8'h01;
    end
    assign parallel_mode = rst_f_reg && (rst_cnt_reg > 8'(`RRS_RST_MAX_CYC));
    //////////////////////////////////////////////////////////////////////
    // serial shifter, sampled on rising serial clock
    logic [15:0] sh_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] readout_reg, lat_reg, pdn_reg;
    wire frame_done = sen_f_reg && sclk_rise && bit_cnt_reg == 5'(`RRS_FRAME_BITS - 1);
    wire [15:0] frame_word = {sh_reg[14:0], sd_f_reg};
    wire readout_on = readout_reg[`RRS_BIT_READOUT];
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sh_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end else if (!sen_f_reg || rst_f_reg) begin
            bit_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            sh_reg <= frame_word;
            // restart at frame end: a one-cycle enable gap is shorter than the pin filter
            bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            readout_reg <= 8'h00;
            lat_reg <= 8'h00;
            pdn_reg <= 8'h00;
        end else if (rst_f_reg) begin
            readout_reg <= 8'h00;
            lat_reg <= 8'h00;
            pdn_reg <= 8'h00;
        end else if (frame_done) begin
            if (frame_word[15:8] == `RRS_ADDR_READOUT) readout_reg <= frame_word[7:0];
            else if (frame_word[15:8] == `RRS_ADDR_LAT && !readout_on) lat_reg <= frame_word[7:0];
            else if (frame_word[15:8] == `RRS_ADDR_PDN && !readout_on) pdn_reg <= frame_word[7:0];
        end
    end
    assign full_power_down = (pdn_reg == `RRS_VAL_PDN);
    // readback: address byte selects, data shifts out on falling edges
    logic [7:0] rd_sh_reg;
    wire [7:0] rd_addr = {sh_reg[6:0], sd_f_reg};
    wire [7:0] rd_sel = (rd_addr == `RRS_ADDR_PDN) ? pdn_reg :
                        (rd_addr == `RRS_ADDR_LAT) ? lat_reg :
                        (rd_addr == `RRS_ADDR_READOUT) ? readout_reg : 8'h00;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) rd_sh_reg <= 8'h00;
        else if (sen_f_reg && sclk_rise && bit_cnt_reg == 5'h07) rd_sh_reg <= rd_sel;
        // shift from the last address fall on, so the host sees each bit once
        else if (sen_f_reg && sclk_fall && bit_cnt_reg >= 5'h08) rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
    end
    //////////////////////////////////////////////////////////////////////
    // pipeline latency selection
    // default low latency
    function automatic logic [4:0] lat_of(input logic [7:0] cfg);
        logic [4:0] base;
        base = !cfg[`RRS_BIT_LOWLAT_DIS] ? 5'(`RRS_LAT_LOW) :
               cfg[`RRS_BIT_OFS_EN] ? 5'(`RRS_LAT_GAIN_OFS) : 5'(`RRS_LAT_GAIN);
        return base + {4'h0, cfg[`RRS_BIT_LATE_CLK]};
    endfunction
    wire [4:0] latency = lat_of(lat_reg);
    wire cmos_mode = lat_reg[`RRS_BIT_CMOS];
    //////////////////////////////////////////////////////////////////////
    // sample period is two mclk: phase 0 and phase 1 give the ddr edges
    logic phase_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) phase_reg <= 1'b0;
        else phase_reg <= ~phase_reg;
    end
    wire samp_en = phase_reg;
    // two-entry buffer between sample source and pipeline
    logic [12:0] buf_reg [0:1];
    logic [1:0] cnt_reg;
    logic wp_reg, rp_reg;
    assign sample_ready = (cnt_reg != 2'h2);
    wire pop = samp_en && cnt_reg != 2'h0 && !full_power_down;
    wire push = sample_ready;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            buf_reg[0] <= 13'h0000;
            buf_reg[1] <= 13'h0000;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) buf_reg[wp_reg] <= {sample_overrange, sample_in};
            if (push) wp_reg <= ~wp_reg;
            if (pop) rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
    // latency delay line, one stage per sample period
    logic [12:0] pipe_reg [0:17];
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 18; i++) pipe_reg[i] <= 13'h0000;
        end else if (samp_en) begin
            pipe_reg[0] <= pop ? buf_reg[rp_reg] : 13'h0000;
            for (int i = 1; i < 18; i++) pipe_reg[i] <= pipe_reg[i-1];
        end
    end
    wire [12:0] tap = pipe_reg[latency - 5'h01];
    //////////////////////////////////////////////////////////////////////
    // output drivers
    logic [5:0] lvds_reg;
    logic [11:0] cmos_reg;
    logic ovr_reg, oclk_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lvds_reg <= 6'h00;
            cmos_reg <= 12'h000;
            ovr_reg <= 1'b0;
            oclk_reg <= 1'b0;
        end else begin
            oclk_reg <= ~phase_reg;
            if (samp_en) begin
                cmos_reg <= cmos_mode ? tap[11:0] : 12'h000;
                ovr_reg <= tap[12];
            end
            for (int k = 0; k < 6; k++) begin
                // pair k holds bits 2k and 2k+1
                lvds_reg[k] <= cmos_mode ? 1'b0 : (samp_en ? tap[2*k] : lvds_reg_odd(k));
            end
        end
    end
    logic [11:0] held_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) held_reg <= 12'h000;
        else if (samp_en) held_reg <= tap[11:0];
    end
    function automatic logic lvds_reg_odd(input int k);
        return held_reg[2*k+1];
    endfunction
    assign link.lvds_pair = lvds_reg;
    assign link.cmos_data = cmos_reg;
    assign link.out_clk = oclk_reg;
    assign link.overrange_or_readback_pin = readout_on ? rd_sh_reg[7] : ovr_reg;
endmodule

//--- logic/rrs_host.sv
`timescale 1ns/1ps
`include "rrs_regs.svh"
module rrs_host #(
    parameter int PWR_CYC = `RRS_PWR_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    rrs_link_if.host link,
    input wire logic wr_valid,
    input wire rrs_pkg::rrs_byte_t wr_addr,
    input wire rrs_pkg::rrs_byte_t wr_data,
    output logic wr_ready,
    output rrs_pkg::rrs_byte_t rd_data,
    output logic rd_valid,
    output logic cfg_done
);
    //////////////////////////////////////////////////////////////////////
    rrs_pkg::rrs_host_st_t st_reg;
    logic [19:0] cnt_reg;
    logic [15:0] sh_reg;
    logic [4:0] bit_reg;
    logic [7:0] rd_reg;
    logic [1:0] div_reg;
    logic sclk_reg;
    wire tick = (div_reg == 2'(`RRS_SCLK_DIV / 2 - 1));
    assign wr_ready = (st_reg == rrs_pkg::RRS_H_IDLE);
    assign cfg_done = wr_ready;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= rrs_pkg::RRS_H_PWR;
            cnt_reg <= 20'h00000;
            sh_reg <= 16'h0000;
            bit_reg <= 5'h00;
            rd_reg <= 8'h00;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            div_reg <= 2'h0;
            sclk_reg <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (st_reg)
                rrs_pkg::RRS_H_PWR: begin
                    cnt_reg <= cnt_reg + 20'h00001;
                    if (cnt_reg == 20'(PWR_CYC - 1)) begin
                        cnt_reg <= 20'h00000;
                        st_reg <= rrs_pkg::RRS_H_RST;
                    end
                end
                rrs_pkg::RRS_H_RST: begin
                    cnt_reg <= cnt_reg + 20'h00001;
                    if (cnt_reg == 20'(`RRS_RST_MIN_CYC + 4)) begin
                        cnt_reg <= 20'h00000;
                        st_reg <= rrs_pkg::RRS_H_GAP;
                    end
                end
                rrs_pkg::RRS_H_GAP: begin
                    cnt_reg <= cnt_reg + 20'h00001;
                    if (cnt_reg == 20'(`RRS_SEN_CYC)) st_reg <= rrs_pkg::RRS_H_IDLE;
                end
                rrs_pkg::RRS_H_IDLE: begin
                    if (wr_valid) begin
                        sh_reg <= {wr_addr, wr_data};
                        bit_reg <= 5'h00;
                        div_reg <= 2'h0;
                        sclk_reg <= 1'b0;
                        st_reg <= rrs_pkg::RRS_H_SHIFT;
                    end
                end
                rrs_pkg::RRS_H_SHIFT: begin
                    div_reg <= tick ? 2'h0 : div_reg + 2'h1;
                    if (tick) begin
                        sclk_reg <= ~sclk_reg;
                        if (sclk_reg) begin
                            sh_reg <= {sh_reg[14:0], 1'b0};
                            bit_reg <= bit_reg + 5'h01;
                            if (bit_reg > 5'h07) rd_reg <= {rd_reg[6:0], link.overrange_or_readback_pin};
                            if (bit_reg == 5'(`RRS_FRAME_BITS - 1)) begin
                                rd_data <= {rd_reg[6:0], link.overrange_or_readback_pin};
                                rd_valid <= 1'b1;
                                st_reg <= rrs_pkg::RRS_H_IDLE;
                            end
                        end
                    end
                end
                default: st_reg <= rrs_pkg::RRS_H_PWR;
            endcase
        end
    end
    assign link.reset = (st_reg == rrs_pkg::RRS_H_RST);
    assign link.serial_enable = (st_reg == rrs_pkg::RRS_H_SHIFT);
    assign link.sclk = sclk_reg;
    assign link.sdata = sh_reg[15];
endmodule

//--- dv/rrs_link_asserts.sv
`timescale 1ns/1ps
`include "rrs_regs.svh"
module rrs_link_asserts #(
    parameter int PWR_CYC = 50
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reset,
    input wire logic serial_enable,
    input wire logic sclk,
    input wire logic out_clk
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    localparam int SEN_CYC = `RRS_SEN_CYC;
    int up_cnt;
    logic rst_seen;
    logic [7:0] gap_cnt;
    logic [5:0] bit_cnt;
    ////////////////////////////////////////////////////////////////
    // helpers: cycles since release, reset seen, sclk rises per frame
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            up_cnt <= 0;
            rst_seen <= 1'b0;
            bit_cnt <= 6'h00;
            gap_cnt <= 8'h00;
        end else begin
            if (up_cnt < PWR_CYC) up_cnt <= up_cnt + 1;
            if (reset) rst_seen <= 1'b1;
            // cycles since reset went low, saturating
            if (reset) gap_cnt <= 8'h00;
            else if (gap_cnt != 8'hFF) gap_cnt <= gap_cnt + 8'h01;
            // wide enough that two back-to-back frames still end on a 16 boundary
            if (!serial_enable) bit_cnt <= 6'h00;
            else if ($rose(sclk)) bit_cnt <= bit_cnt + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_pwr_delay; $rose(reset) |-> up_cnt >= PWR_CYC - 1; endproperty
    a_pwr_delay: assert property (p_pwr_delay) else $error("reset pulse too early");
    property p_rst_width; $rose(reset) |-> reset [*6] ##1 !reset; endproperty
    a_rst_width: assert property (p_rst_width) else $error("reset pulse width wrong");
    property p_sen_gap; serial_enable |-> gap_cnt >= SEN_CYC; endproperty
    a_sen_gap: assert property (p_sen_gap) else $error("enable too soon after reset");
    property p_sen_no_rst; serial_enable |-> !reset && rst_seen; endproperty
    a_sen_no_rst: assert property (p_sen_no_rst) else $error("enable without prior reset");
    property p_rst_once; $rose(reset) |-> !rst_seen; endproperty
    a_rst_once: assert property (p_rst_once) else $error("second reset pulse");
    property p_frame_bits; $fell(serial_enable) |-> bit_cnt[3:0] == 4'h0 && bit_cnt != 6'h00; endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("frame not 16 bits");
    property p_sclk_half; $rose(sclk) |-> sclk [*2] ##1 !sclk; endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("sclk high time wrong");
    property p_outclk; out_clk |=> !out_clk; endproperty
    a_outclk: assert property (p_outclk) else $error("output clock high too long");
endmodule

//--- dv/reset_readout_sequencing_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module reset_readout_sequencing_bench;
    localparam int PWR = 50;
    localparam rrs_pkg::rrs_sample_t MARK = 12'hF0A;
    logic mclk, arst_n, wr_valid, wr_ready, rd_valid, rst_b, send_m;
    logic sample_overrange, sample_ready, full_power_down, parallel_mode, pm_b, cfg_done;
    rrs_pkg::rrs_byte_t wr_addr, wr_data, rd_data;
    rrs_pkg::rrs_sample_t sample_in;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    int err_total, checks_done, ovr_mode, l[4];
    time t0;
    rrs_link_if link_a();
    rrs_link_if link_b();
    // second link: bench plays a host that holds reset as it likes
    assign link_b.reset = rst_b;
    assign link_b.serial_enable = 1'b0;
    assign link_b.sclk = 1'b0;
    assign link_b.sdata = 1'b0;
    rrs_host #(.PWR_CYC(PWR)) rrs_host_inst(.mclk(mclk), .arst_n(arst_n), .link(link_a), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .cfg_done(cfg_done));
    rrs_device rrs_device_inst(.mclk(mclk), .arst_n(arst_n), .link(link_a), .sample_in(sample_in),
        .sample_overrange(sample_overrange), .sample_ready(sample_ready), .full_power_down(full_power_down),
        .parallel_mode(parallel_mode));
    rrs_device rrs_device_alt_inst(.mclk(mclk), .arst_n(arst_n), .link(link_b), .sample_in(sample_in),
        .sample_overrange(sample_overrange), .sample_ready(), .full_power_down(), .parallel_mode(pm_b));
    rrs_link_asserts #(.PWR_CYC(PWR)) rrs_link_asserts_inst(.mclk(mclk), .arst_n(arst_n),
        .reset(link_a.reset), .serial_enable(link_a.serial_enable), .sclk(link_a.sclk), .out_clk(link_a.out_clk));
    ////////////////////////////////////////////////////////////////
    task print_verdict();
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one frame; held until taken, the readback note queued at acceptance
    task automatic do_wr(input rrs_pkg::rrs_byte_t a, input rrs_pkg::rrs_byte_t d, input logic [8:0] nt);
        logic rdy;
        int n;
        rdy = 1'b0;
        n = 0;
        @(posedge mclk);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        while (!rdy && n < 5000) begin
            #1 rdy = (wr_ready === 1'b1);
            @(posedge mclk);
            n++;
        end
        if (!rdy) err_total++;
        exp_q.push_back(nt);
        wr_valid <= 1'b0;
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000) err_total++;
        repeat (20) @(posedge mclk);
    endtask
    // cycles from marker hand-off to marker on the word pins
    task automatic measure(output int lat);
        int n;
        n = 0;
        #1 send_m = 1'b1;
        while (link_a.cmos_data !== MARK && n < 300) begin
            @(posedge mclk);
            #1 n++;
        end
        lat = int'(($time - t0) / 10);
        `CHK(n < 300, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // readback monitor: oldest note against each answer
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            note = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1FF;
            if (note[8]) `CHK(rd_data, note[7:0])
        end
    end
    // sample feeder; background keeps bit 11 clear so the marker stays unique
    initial begin
        logic rdy;
        sample_in = 12'h000;
        sample_overrange = 1'b0;
        // seed the thread that draws the random samples
        void'($urandom(16150));
        forever begin
            #1 rdy = (sample_ready === 1'b1);
            @(posedge mclk);
            if (rdy) begin
                if (sample_in === MARK && send_m) begin
                    t0 = $time;
                    send_m = 1'b0;
                end
                sample_in <= send_m ? MARK : 12'($urandom & 32'h7FF);
                sample_overrange <= (ovr_mode == 0) ? 1'($urandom) : (ovr_mode == 1);
            end
        end
    end
    initial begin
        #300000;
        err_total++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [5:0] prev;
        arst_n = 1'b0;
        wr_valid = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rst_b = 1'b0;
        send_m = 1'b0;
        ovr_mode = 0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        do_wr(8'h43, 8'h40, 9'h000);
        settle();
        #1 `CHK(full_power_down, 1'b1)
        `CHK(cfg_done, 1'b1)
        `CHK(sample_ready, 1'b0)
        do_wr(8'h00, 8'h01, 9'h000);
        do_wr(8'h43, 8'h55, 9'h140);
        do_wr(8'h01, 8'h00, 9'h100);
        do_wr(8'h00, 8'h00, 9'h000);
        settle();
        // write to 43h during readout must have been dropped
        #1 `CHK(full_power_down, 1'b1)
        do_wr(8'h43, 8'h00, 9'h000);
        settle();
        #1 `CHK(full_power_down, 1'b0)
        for (int v = 1; v <= 2; v++) begin
            ovr_mode = v;
            repeat (60) @(posedge mclk);
            #1 `CHK(link_a.overrange_or_readback_pin, 1'(v == 1))
        end
        ovr_mode = 0;
        // latency ladder, relative so buffer delay cancels
        foreach (l[i]) begin
            do_wr(8'h01, (i == 0) ? 8'h10 : (i == 1) ? 8'h13 : (i == 2) ? 8'h17 : 8'h1B, 9'h000);
            settle();
            measure(l[i]);
        end
        `CHK(l[1] - l[0], 12)
        `CHK(l[2] - l[0], 14)
        `CHK(l[3] - l[1], 2)
        do_wr(8'h01, 8'h00, 9'h000);
        settle();
        prev = 6'h00;
        #1 send_m = 1'b1;
        // odd half only: background samples cannot show 33h there
        for (int n = 0; n < 300 && !(link_a.lvds_pair === 6'h33 && link_a.out_clk === 1'b1); n++) begin
            prev = link_a.lvds_pair;
            @(posedge mclk);
            #1;
        end
        `CHK(prev, 6'h30)
        `CHK(link_a.lvds_pair, 6'h33)
        // short pulse on the spare device, then a held-high one
        @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 `CHK(pm_b, 1'b0)
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (20) @(posedge mclk);
        // held high as for pin configuration
        rst_b <= 1'b1;
        repeat (110) @(posedge mclk);
        #1 `CHK(pm_b, 1'b1)
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (10) @(posedge mclk);
        #1 `CHK(pm_b, 1'b0)
        `CHK(parallel_mode, 1'b0)
        print_verdict();
    end
endmodule
